// [rtl/roafd_pkg.sv]
// roafd_pkg: shared constants and types for the relay output block
// assumes one 200 MHz clock and a synchronous active-high reset
package roafd_pkg;
    // number of output relays in the assembly group
    localparam int NUM_RELAYS = 6;
    // assigned signals per relay, or-ed together
    localparam int SIGS_PER_RELAY = 7;
    // clock period in ns
    localparam int CLK_PERIOD_NS = 5;
    // hold timer resolution: 10 ms, written in ns
    localparam int HOLD_TICK_NS = 10000000;
    // cycles per hold tick, derived from the two times above
    localparam int HOLD_TICK_CYCLES = HOLD_TICK_NS / CLK_PERIOD_NS;
    // width of a hold time setting in ticks (300.00 s = 30000 ticks)
    localparam int HOLD_W = 15;
    // hold time value after reset (0.00 s)
    localparam logic [HOLD_W-1:0] HOLD_RESET = 15'h0000;
    // tick counter width
    localparam int TICK_W = 32;

    // three-way force setting
    typedef enum logic [1:0] {
        ROAFD_FORCE_NORMAL = 2'h0,
        ROAFD_FORCE_DEENERGIZED = 2'h1,
        ROAFD_FORCE_ENERGIZED = 2'h2
    } roafd_force_t;
endpackage : roafd_pkg

// [rtl/roafd_hold.sv]
// roafd_hold: minimum hold time of one relay output
// assumes tick is a one-cycle pulse on ref_clk from the owner's divider
`timescale 1ns/100ps
`default_nettype none
module roafd_hold (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // timing
    input wire logic tick,
    input wire logic [roafd_pkg::HOLD_W-1:0] hold_ticks,
    // state in and out
    input wire logic state_in,
    output logic state_out,
    output logic busy
);
    // all state of the hold timer
    typedef struct packed {
        logic held;
        logic [roafd_pkg::HOLD_W-1:0] cnt;
    } roafd_hold_state_t;

    roafd_hold_state_t s_reg;
    roafd_hold_state_t s_next;

    // a change is passed once, then frozen until the count runs out
    always_comb begin
        s_next = s_reg;
        if (s_reg.cnt != roafd_pkg::HOLD_RESET) begin
            // running: count down on each tick
            if (tick) begin
                s_next.cnt = s_reg.cnt - 15'h0001;
            end
        end else if (state_in != s_reg.held) begin
            // new state taken, hold window starts
            s_next.held = state_in;
            s_next.cnt = hold_ticks;
        end
    end

    // register the state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign state_out = s_reg.held;
    assign busy = (s_reg.cnt != roafd_pkg::HOLD_RESET);
endmodule : roafd_hold
`default_nettype wire

// [rtl/roafd_top.sv]
// roafd_top: acknowledge, system-ok, disarm and force logic of a relay group
// assumes protection signals, ack signals and service commands come from logic
// on ref_clk; the panel button arrives from a pin and is synchronised here.
// Overview of operation
// - panel clear button acknowledges relays
// - per-relay ack signal works only when latching is on
// - external ack rising acknowledges all relays
// - supervisory ack acknowledges all relays
// - system-ok relay has no settings
// - system-ok drops on internal fault
// - system-ok off during start-up
// - after start-up energise system-ok and LED
// - disarm needs disarm-enable first, resets inactive
// - disarm only unlatched relays not in hold
// - zone interlock and supervision ignore disarm
// - per-relay force normal, off or on
// - group force overrides single force
// - ack needs signals gone and hold expired
// - relay is or of seven invertible signals
// - unlatched tracks, latched stores until ack
`timescale 1ns/100ps
`default_nettype none
module roafd_top #(
    parameter int NUM_RELAYS = roafd_pkg::NUM_RELAYS,
    parameter int SIGS = roafd_pkg::SIGS_PER_RELAY,
    parameter int TICK_DIV = roafd_pkg::HOLD_TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // protection signals and their inversion flags, relay i at [i*SIGS +: SIGS]
    input wire logic [NUM_RELAYS*SIGS-1:0] assigned_sig,
    input wire logic [NUM_RELAYS*SIGS-1:0] sig_invert,
    // per-relay settings and the group force setting
    input wire logic [NUM_RELAYS-1:0] latch_en,
    input wire logic [NUM_RELAYS*roafd_pkg::HOLD_W-1:0] hold_ticks,
    input wire logic [NUM_RELAYS*2-1:0] force_single_output,
    input wire logic [1:0] force_all_outputs,
    // acknowledge sources
    input wire logic panel_clear_btn,
    input wire logic [NUM_RELAYS-1:0] relay_ack_sig,
    input wire logic external_ack_module,
    input wire logic scada_ack,
    // disarm service commands
    input wire logic disarm_ctrl,
    input wire logic disarm_cmd,
    // self supervision
    input wire logic boot_done,
    input wire logic internal_fault,
    // zone interlocking signal
    input wire logic zone_interlock_in,
    // outputs
    output logic [NUM_RELAYS-1:0] relay_coil,
    output logic [NUM_RELAYS-1:0] relay_latched,
    output logic [NUM_RELAYS-1:0] relay_disarmed,
    output logic zone_interlock_out,
    output logic system_ok_contact,
    output logic system_ok_led
);
    // all state of the block
    typedef struct packed {
        logic btn_s1;
        logic btn_s2;
        logic btn_prev;
        logic ext_prev;
        logic cmd_prev;
        logic [NUM_RELAYS-1:0] latched;
        logic [NUM_RELAYS-1:0] disarmed;
        logic [NUM_RELAYS-1:0] coil;
        logic zone;
        logic sysok;
        logic [roafd_pkg::TICK_W-1:0] tick_cnt;
    } roafd_state_t;

    roafd_state_t s_reg;
    roafd_state_t s_next;

    logic tick; // hold time base pulse
    logic [NUM_RELAYS-1:0] logical; // or of assigned signals
    logic [NUM_RELAYS-1:0] pre_hold; // state before the hold timer
    logic [NUM_RELAYS-1:0] held; // state after the hold timer
    logic [NUM_RELAYS-1:0] hold_busy; // hold window running
    logic [NUM_RELAYS-1:0] clear_req; // combined acknowledge per relay
    logic common_ack; // acknowledges addressed to all relays
    logic disarm_go; // accepted disarm step

    // apply a force setting on top of the normal state
    function automatic logic apply_force(input logic [1:0] f, input logic normal);
        case (f)
            roafd_pkg::ROAFD_FORCE_ENERGIZED: apply_force = 1'b1;
            roafd_pkg::ROAFD_FORCE_DEENERGIZED: apply_force = 1'b0;
            default: apply_force = normal;
        endcase
    endfunction : apply_force

    // divider width, declared ahead of the compare that sizes with it
    localparam int TICK_W = roafd_pkg::TICK_W;
    // one pulse every TICK_DIV cycles
    assign tick = (s_reg.tick_cnt == TICK_W'(TICK_DIV - 1));

    // button edge, external ack edge and supervisory ack reach every relay
    assign common_ack = (s_reg.btn_s2 & ~s_reg.btn_prev)
        | (external_ack_module & ~s_reg.ext_prev)
        | scada_ack;

    // disarm is the second step, taken on the command's rising edge
    assign disarm_go = disarm_ctrl & disarm_cmd & ~s_reg.cmd_prev;

    // per relay: signal or, latch, acknowledge and hold timer
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RELAYS; gi++) begin : g_relay
            // or of the invertible assigned signals
            assign logical[gi] = |(assigned_sig[gi*SIGS +: SIGS]
                ^ sig_invert[gi*SIGS +: SIGS]);
            // latched relays keep their set state
            assign pre_hold[gi] = logical[gi] | s_reg.latched[gi];
            // every acknowledge source merged, own signal gated by latch enable
            assign clear_req[gi] = common_ack
                | (relay_ack_sig[gi] & latch_en[gi]);
            roafd_hold u_hold (
                .ref_clk(ref_clk),
                .rst(rst),
                .tick(tick),
                .hold_ticks(hold_ticks[gi*roafd_pkg::HOLD_W +: roafd_pkg::HOLD_W]),
                .state_in(pre_hold[gi]),
                .state_out(held[gi]),
                .busy(hold_busy[gi])
            );
        end
    endgenerate

    // next-state logic of the whole block
    always_comb begin
        s_next = s_reg;
        // pin synchroniser, second stage feeds the edge detector
        s_next.btn_s1 = panel_clear_btn;
        s_next.btn_s2 = s_reg.btn_s1;
        s_next.btn_prev = s_reg.btn_s2;
        s_next.ext_prev = external_ack_module;
        s_next.cmd_prev = disarm_cmd;
        // hold time base divider
        if (tick) begin
            s_next.tick_cnt = '0;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 32'h00000001;
        end
        for (int i = 0; i < NUM_RELAYS; i++) begin
            // latch sets on the logical state while latching is on
            if (latch_en[i] && logical[i]) begin
                s_next.latched[i] = 1'b1;
            end else if (clear_req[i] && !logical[i] && !hold_busy[i]) begin
                // ack takes effect only with signals gone and hold over
                s_next.latched[i] = 1'b0;
            end
            // disarm only unlatched relays outside a hold window
            if (disarm_go && !s_reg.latched[i] && !hold_busy[i]) begin
                s_next.disarmed[i] = 1'b1;
            end
            // group force first, single force next, then normal state
            if (force_all_outputs != roafd_pkg::ROAFD_FORCE_NORMAL) begin
                s_next.coil[i] = apply_force(force_all_outputs, 1'b0);
            end else begin
                s_next.coil[i] = apply_force(force_single_output[i*2 +: 2],
                    held[i] & ~s_reg.disarmed[i]);
            end
        end
        // the command returning inactive re-arms the group
        if (!disarm_cmd) begin
            s_next.disarmed = '0;
        end
        // zone interlocking bypasses disarm
        s_next.zone = zone_interlock_in;
        // fixed life contact: boot finished and no fault
        s_next.sysok = boot_done & ~internal_fault;
    end

    // register the state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flip-flops
    assign relay_coil = s_reg.coil;
    assign relay_latched = s_reg.latched;
    assign relay_disarmed = s_reg.disarmed;
    assign zone_interlock_out = s_reg.zone;
    assign system_ok_contact = s_reg.sysok;
    assign system_ok_led = s_reg.sysok;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_disarm_step;
        disarm_ctrl && disarm_cmd && !$past(disarm_cmd);
    endsequence

    a_sysok_fault_drop: assert property (internal_fault |=> !system_ok_contact)
        else $error("system ok stayed on during fault");
    a_sysok_boot_hold: assert property (!boot_done |=> !system_ok_contact && !system_ok_led)
        else $error("system ok on before boot done");
    a_sysok_on_ready: assert property (boot_done && !internal_fault |=> system_ok_led)
        else $error("system ok not energised after boot");
    a_group_force_on: assert property (
        force_all_outputs == roafd_pkg::ROAFD_FORCE_ENERGIZED |=> &relay_coil)
        else $error("group force energised not applied");
    a_group_force_off: assert property (
        force_all_outputs == roafd_pkg::ROAFD_FORCE_DEENERGIZED |=> relay_coil == '0)
        else $error("group force de-energised not applied");
    a_single_force_on: assert property (
        force_all_outputs == roafd_pkg::ROAFD_FORCE_NORMAL
        && force_single_output[1:0] == roafd_pkg::ROAFD_FORCE_ENERGIZED |=> relay_coil[0])
        else $error("single force energised not applied");
    a_disarm_needs_ctrl: assert property (
        !disarm_ctrl && relay_disarmed == '0 |=> relay_disarmed == '0)
        else $error("disarm accepted without enable");
    // latch checks watch relay 1, the relay that carries the latching traffic
    a_disarm_spares_latched: assert property (
        s_disarm_step ##0 relay_latched[1] |=> !relay_disarmed[1] || $past(relay_disarmed[1]))
        else $error("latched relay disarmed");
    a_zone_passes: assert property (
        s_disarm_step ##1 1'b1 |-> zone_interlock_out == $past(zone_interlock_in))
        else $error("zone interlock disturbed by disarm");
    a_latch_stays: assert property (
        relay_latched[1] && !clear_req[1] |=> relay_latched[1])
        else $error("latched relay released without ack");
    a_ack_blocked: assert property (
        relay_latched[1] && (logical[1] || hold_busy[1]) |=> relay_latched[1])
        else $error("ack took effect too early");
    a_scada_clears: assert property (
        scada_ack && relay_latched[1] && !logical[1] && !hold_busy[1] |=> !relay_latched[1])
        else $error("supervisory ack did not clear");
endmodule : roafd_top
`default_nettype wire

// [dv/roafd_panel_model.sv]
// roafd_panel_model: operator panel and supervisory link at the far side
// assumes requests from the bench are level pulses on ref_clk
`timescale 1ns/100ps
`default_nettype none
module roafd_panel_model (
    // clock
    input wire logic ref_clk,
    // requests from the bench
    input wire logic press_req,
    input wire logic scada_req,
    // drives towards the block
    output logic panel_clear_btn,
    output logic scada_ack
);
    // button pin is asynchronous: press off-grid, hold four cycles, release off-grid
    initial begin
        panel_clear_btn = 1'b0;
        forever begin
            @(posedge press_req);
            #2.3 panel_clear_btn = 1'b1;
            repeat (4) @(posedge ref_clk);
            #3.1 panel_clear_btn = 1'b0;
        end
    end
    // supervisory ack is a one-cycle level following the request
    initial scada_ack = 1'b0;
    always @(posedge ref_clk) begin
        scada_ack <= #1 scada_req;
    end
endmodule : roafd_panel_model
`default_nettype wire

// [dv/roafd_top_tb.sv]
// roafd_top_tb: directed bench for ack, system-ok, disarm and force
// assumes roafd_pkg and roafd_top are compiled first
`timescale 1ns/100ps
`default_nettype none
module roafd_top_tb;
    localparam int NR = roafd_pkg::NUM_RELAYS;
    logic ref_clk, rst, ext, dctl, dcmd, boot, fault, zin, press_req, scada_req, btn, sack;
    logic [NR*7-1:0] sig, inv; // signals and inversion flags
    logic [NR-1:0] latch_en, rack, coil, latched, disarmed;
    logic [NR*2-1:0] fso; // single force codes
    logic [1:0] fall; // group force code
    logic [NR*roafd_pkg::HOLD_W-1:0] hold; // hold times per relay in ticks
    logic zout, sok, sled;
    int n_mismatch, total_checks;
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    roafd_panel_model u_roafd_panel_model (.ref_clk(ref_clk), .press_req(press_req),
        .scada_req(scada_req), .panel_clear_btn(btn), .scada_ack(sack));
    roafd_top #(.TICK_DIV(4)) u_roafd_top (.ref_clk(ref_clk), .rst(rst), .assigned_sig(sig),
        .sig_invert(inv), .latch_en(latch_en), .hold_ticks(hold), .force_single_output(fso),
        .force_all_outputs(fall), .panel_clear_btn(btn), .relay_ack_sig(rack),
        .external_ack_module(ext), .scada_ack(sack), .disarm_ctrl(dctl), .disarm_cmd(dcmd),
        .boot_done(boot), .internal_fault(fault), .zone_interlock_in(zin),
        .relay_coil(coil), .relay_latched(latched), .relay_disarmed(disarmed),
        .zone_interlock_out(zout), .system_ok_contact(sok), .system_ok_led(sled));
    // wait n edges, then move off the edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    // compare seen against expected and count
    task automatic chk(input logic [NR-1:0] seen, input logic [NR-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one acknowledge request from source 0 button, 1 own signal, 2 external, 3 link
    task automatic ack(input int src);
        case (src)
            0: begin
                press_req = 1'b1;
                step(1);
                press_req = 1'b0;
                step(8);
            end
            1: begin
                rack[1] = 1'b1;
                step(1);
                rack[1] = 1'b0;
            end
            2: begin
                ext = 1'b1;
                step(1);
                ext = 1'b0;
            end
            default: begin
                scada_req = 1'b1;
                step(1);
                scada_req = 1'b0;
            end
        endcase
        step(4);
    endtask : ack
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // bound on the whole run
    initial begin
        #100us;
        n_mismatch++;
        wrap_up();
    end
    // main sequence
    initial begin
        {rst, ext, dctl, dcmd, boot, fault, zin, press_req, scada_req} = 9'h100;
        {sig, inv, latch_en, rack, fso, fall, hold} = '0;
        repeat (3) @(posedge ref_clk);
        #1 rst = 1'b0;
        // system-ok contact life cycle
        step(3);
        chk(NR'(sok), 6'h00);
        boot = 1'b1;
        step(3);
        chk(NR'({sok, sled}), 6'h03);
        fault = 1'b1;
        step(3);
        chk(NR'({sok, sled}), 6'h00);
        fault = 1'b0;
        $display("test sysok done");
        // unlatched relay tracks or of inverted signals
        sig[6] = 1'b1;
        step(3);
        chk(coil, 6'h01);
        inv[6] = 1'b1;
        step(3);
        chk(coil, 6'h00);
        {sig[6], inv[6]} = 2'h0;
        step(3);
        $display("test track done");
        // latched relay 1 and each ack source, refused while signal active
        latch_en[1] = 1'b1;
        for (int s = 0; s < 4; s++) begin
            sig[7] = 1'b1;
            step(3);
            ack(s);
            chk(latched, 6'h02);
            sig[7] = 1'b0;
            step(3);
            chk(coil, 6'h02);
            ack(s);
            chk(coil | latched, 6'h00);
        end
        $display("test ack done");
        // disarm two-step, latched relay 1 spared, interlock passes
        sig[7] = 1'b1;
        step(3);
        sig[7] = 1'b0;
        dcmd = 1'b1;
        step(3);
        chk(disarmed, 6'h00);
        dcmd = 1'b0;
        dctl = 1'b1;
        step(1);
        {dcmd, zin, sig[0]} = 3'h7;
        step(3);
        chk(disarmed, 6'h3D);
        chk(NR'(zout), 6'h01);
        chk(coil, 6'h02);
        dcmd = 1'b0;
        step(3);
        chk(coil, 6'h03);
        {dctl, zin, sig[0]} = 3'h0;
        ack(3);
        $display("test disarm done");
        // hold window of two ticks: relay 2 spared by disarm, relay 1 ack refused
        hold = {NR{15'h0002}};
        {dctl, sig[7], sig[14]} = 3'h7;
        step(1);
        {dcmd, sig[7], sig[14]} = 3'h4;
        step(1);
        chk(disarmed, 6'h39);
        dcmd = 1'b0;
        ack(3);
        chk(latched, 6'h02);
        // own ack signal has no effect with latching off, refused ack not kept
        latch_en[1] = 1'b0;
        step(8);
        ack(1);
        chk(latched, 6'h02);
        latch_en[1] = 1'b1;
        ack(3);
        chk(coil | latched, 6'h00);
        {hold, dctl} = '0;
        $display("test hold done");
        // single force codes then group override
        for (int f = 0; f < 3; f++) begin
            fso[5:4] = 2'(f);
            fso[1:0] = 2'(f);
            step(3);
            chk(coil, (f == 2) ? 6'h05 : 6'h00);
        end
        fall = 2'h1;
        step(3);
        chk(coil, 6'h00);
        fall = 2'h2;
        step(3);
        chk(coil, 6'h3F);
        {fall, fso} = '0;
        step(3);
        chk(coil, 6'h00);
        $display("test force done");
        wrap_up();
    end
endmodule : roafd_top_tb
`default_nettype wire
